// ===== hw/t1fis_pkg.sv
`default_nettype none
package t1fis_pkg;
  // register byte offsets
  localparam int ADR_W = 4;
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_ENABLE = 4'h4;
  localparam logic [3:0] OFS_CTRL = 4'h8;
  localparam logic [3:0] OFS_LOSS = 4'hC;

  // framer_event_status bit positions
  localparam int BIT_YEL_CHG = 7;
  localparam int BIT_YEL_LIVE = 6;
  localparam int BIT_SIG = 5;
  localparam int BIT_ALIGN = 4;
  localparam int BIT_LOSS_CHG = 3;
  localparam int BIT_MIMIC = 2;
  localparam int BIT_CRC6 = 1;
  localparam int BIT_FBIT = 0;
  localparam logic [7:0] STICKY_MASK = 8'hBF;
  localparam logic [7:0] WCLR_MASK = 8'h3F;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;

  // control register fields
  localparam int CTRL_YEL_SW = 2;
  localparam int CTRL_RBS_EN = 3;
  localparam logic [7:0] CTRL_MASK = 8'h0C;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // loss-of-frame configuration fields
  localparam int LOSS_W = 4;
  localparam int LOSS_THR_LSB = 0;
  localparam int LOSS_WIN_LSB = 8;
  localparam logic [LOSS_W-1:0] LOSS_THR_RST = 4'h2;
  localparam logic [LOSS_W-1:0] LOSS_WIN_RST = 4'h4;

  // signaling channels
  localparam int NCH_DEF = 24;
  localparam int CHAN_W = 5;

  typedef enum logic [1:0] {
    ST_INFRAME = 2'b01,
    ST_OOF = 2'b10
  } t1fis_frm_e;

  typedef struct packed {
    logic align_shift;
    logic mimic;
    logic crc6_err;
    logic fbit_err;
    logic fbit_ok;
    logic reframe;
  } t1fis_rx_s;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [3:0] abcd;
  } t1fis_sig_s;
endpackage
`default_nettype wire

// ===== hw/t1fis_flag.sv
`default_nettype none
module t1fis_flag (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // set and clear requests
  input wire logic set_i,
  input wire logic clr_i,
  // sticky state
  output logic q_o
);
  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hw/t1fis_top.sv
// Local design decisions: the register addresses and the Wishbone slave port.
`default_nettype none
// Behaviour
// - sticky flags (bits 7, 5-0) hold until status read or, for bits 5-0 only, a one is written to them
// - bit 7 latches yellow alarm state change
// - bit 6 shows live yellow alarm
// - switch bit selects egress yellow source
// - bit 5 sets on signaling change
// - signaling flag only with robbed-bit enabled
// - bit 4 sets on alignment shift
// - bit 3 sets on loss declare and clear
// - loss declared at threshold errors in window
// - bit 2 sets on frame mimic
// - bit 1 sets on crc-6 error
// - bit 0 sets on framing bit error
// - framing errors below threshold keep frame state
// - interrupt only for enabled set flags
// - enables reset to zero, one enables
module t1fis_top #(
  parameter int NCH = t1fis_pkg::NCH_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [t1fis_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // receive framer events
  input wire t1fis_pkg::t1fis_rx_s rx_evt_i,
  input wire t1fis_pkg::t1fis_sig_s sig_i,
  input wire logic yel_ingress_i,
  input wire logic yel_egress_i,
  // status outputs
  output logic frame_loss_o,
  output logic irq_o
);
  import t1fis_pkg::*;

  logic [7:0] enable;
  logic [7:0] ctrl;
  logic [LOSS_W-1:0] loss_thr;
  logic [LOSS_W-1:0] loss_win;
  logic yel_live;
  wire [7:0] flags;
  wire [7:0] ev;
  wire [7:0] clr;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i;
  wire bus_rd = bus_req & ~wb_we_i;
  wire hit_status = (wb_adr_i == OFS_STATUS);
  wire hit_enable = (wb_adr_i == OFS_ENABLE);
  wire hit_ctrl = (wb_adr_i == OFS_CTRL);
  wire hit_loss = (wb_adr_i == OFS_LOSS);
  wire lane0_wr = bus_wr & wb_sel_i[0];
  wire lane1_wr = bus_wr & wb_sel_i[1];

  wire [31:0] loss_word = {20'h0_0000, loss_win, 4'h0, loss_thr};
  wire [31:0] rd_word = hit_status ? {24'h00_0000, flags} :
                        hit_enable ? {24'h00_0000, enable} :
                        hit_ctrl ? {24'h00_0000, ctrl} :
                        hit_loss ? loss_word : 32'h0000_0000;

  wire rd_clear = bus_rd & hit_status;
  wire [7:0] wr_clear = (lane0_wr & hit_status) ?
                        (wb_dat_i[7:0] & WCLR_MASK) : 8'h00;
  assign clr = ({8{rd_clear}} & STICKY_MASK) | wr_clear;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable <= ENABLE_RST;
      ctrl <= CTRL_RST;
      loss_thr <= LOSS_THR_RST;
      loss_win <= LOSS_WIN_RST;
    end else begin
      if (lane0_wr && hit_enable) begin
        enable <= wb_dat_i[7:0] & STICKY_MASK;
      end
      if (lane0_wr && hit_ctrl) begin
        ctrl <= wb_dat_i[7:0] & CTRL_MASK;
      end
      if (lane0_wr && hit_loss) begin
        loss_thr <= wb_dat_i[LOSS_THR_LSB +: LOSS_W];
      end
      if (lane1_wr && hit_loss) begin
        loss_win <= wb_dat_i[LOSS_WIN_LSB +: LOSS_W];
      end
    end
  end

  wire yel_sel = ctrl[CTRL_YEL_SW] ? yel_egress_i : yel_ingress_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      yel_live <= 1'b0;
    end else begin
      yel_live <= yel_sel;
    end
  end

  // signaling history per channel
  logic [3:0] sig_mem [NCH];
  logic [NCH-1:0] sig_seen;
  wire chan_ok = sig_i.valid & (sig_i.chan < CHAN_W'(NCH));
  wire sig_diff = sig_seen[sig_i.chan] &
                  (sig_mem[sig_i.chan] != sig_i.abcd);
  wire sig_chg = chan_ok & ctrl[CTRL_RBS_EN] & sig_diff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sig_seen <= '0;
    end else if (chan_ok) begin
      sig_seen[sig_i.chan] <= 1'b1;
      sig_mem[sig_i.chan] <= sig_i.abcd;
    end
  end

  // frame loss detector
  t1fis_frm_e frm_state;
  t1fis_frm_e next_state;
  logic [LOSS_W-1:0] win_cnt;
  logic [LOSS_W-1:0] err_cnt;
  logic [LOSS_W-1:0] next_win;
  logic [LOSS_W-1:0] next_err;
  wire fbit_seen = rx_evt_i.fbit_ok | rx_evt_i.fbit_err;
  wire [LOSS_W:0] err_sum = {1'b0, err_cnt} +
                            {{LOSS_W{1'b0}}, rx_evt_i.fbit_err};
  wire [LOSS_W:0] win_sum = {1'b0, win_cnt} + {{LOSS_W{1'b0}}, 1'b1};
  wire thr_hit = (loss_thr != '0) & (err_sum >= {1'b0, loss_thr});
  wire win_end = (win_sum >= {1'b0, loss_win});
  wire declare = (frm_state == ST_INFRAME) & fbit_seen & thr_hit;
  wire regain = (frm_state == ST_OOF) & rx_evt_i.reframe;

  // framing errors below threshold do not drop frame
  always_comb begin
    next_state = frm_state;
    next_win = win_cnt;
    next_err = err_cnt;
    case (frm_state)
      ST_INFRAME: begin
        if (declare) begin
          next_state = ST_OOF;
          next_win = '0;
          next_err = '0;
        end else if (fbit_seen && win_end) begin
          next_win = '0;
          next_err = '0;
        end else if (fbit_seen) begin
          next_win = win_sum[LOSS_W-1:0];
          next_err = err_sum[LOSS_W-1:0];
        end
      end
      ST_OOF: begin
        if (regain) begin
          next_state = ST_INFRAME;
        end
      end
      default: begin
        next_state = ST_INFRAME;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_state <= ST_INFRAME;
      win_cnt <= '0;
      err_cnt <= '0;
      frame_loss_o <= 1'b0;
    end else begin
      frm_state <= next_state;
      win_cnt <= next_win;
      err_cnt <= next_err;
      frame_loss_o <= (next_state == ST_OOF);
    end
  end

  assign ev[BIT_YEL_CHG] = yel_sel ^ yel_live;
  assign ev[BIT_YEL_LIVE] = 1'b0;
  assign ev[BIT_SIG] = sig_chg;
  assign ev[BIT_ALIGN] = rx_evt_i.align_shift;
  assign ev[BIT_LOSS_CHG] = declare | regain;
  assign ev[BIT_MIMIC] = rx_evt_i.mimic;
  assign ev[BIT_CRC6] = rx_evt_i.crc6_err;
  assign ev[BIT_FBIT] = rx_evt_i.fbit_err;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (gi == BIT_YEL_LIVE) begin : g_live
        assign flags[gi] = yel_live;
      end else begin : g_sticky
        t1fis_flag u_flag (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .set_i(ev[gi]),
          .clr_i(clr[gi]),
          .q_o(flags[gi])
        );
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flags & enable & STICKY_MASK);
    end
  end

  a_read_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_clear |=> ((flags & STICKY_MASK) ==
                  ($past(ev) & STICKY_MASK)))
    else $error("status read did not clear sticky flags");

  a_yel_change: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (yel_live != $past(yel_live)) |-> flags[BIT_YEL_CHG])
    else $error("yellow change not latched");

  a_live_low: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!yel_sel ##1 !yel_sel) |-> !flags[BIT_YEL_LIVE])
    else $error("live yellow bit stuck high");

  a_yel_egress: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctrl[CTRL_YEL_SW] && yel_egress_i) |=> yel_live)
    else $error("egress yellow source not followed");

  a_yel_ingress: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl[CTRL_YEL_SW] && yel_ingress_i) |=> yel_live)
    else $error("ingress yellow source not followed");

  a_sig_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (chan_ok && ctrl[CTRL_RBS_EN] && sig_diff) |=> flags[BIT_SIG])
    else $error("signaling change not latched");

  a_sig_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl[CTRL_RBS_EN] && !flags[BIT_SIG]) |=> !flags[BIT_SIG])
    else $error("signaling flag set while disabled");

  a_align_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.align_shift |=> flags[BIT_ALIGN])
    else $error("alignment shift not latched");

  a_loss_change: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $changed(frm_state) |-> (flags[BIT_LOSS_CHG] && frame_loss_o ==
                             (frm_state == ST_OOF)))
    else $error("frame loss change not latched");

  a_loss_declare: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (frm_state == ST_INFRAME && rx_evt_i.fbit_err &&
     loss_thr == 4'h1) |=> (frm_state == ST_OOF))
    else $error("loss not declared at threshold");

  a_mimic_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.mimic |=> flags[BIT_MIMIC])
    else $error("frame mimic not latched");

  a_crc_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.crc6_err |=> flags[BIT_CRC6])
    else $error("crc-6 error not latched");

  a_fbit_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_evt_i.fbit_err |=> flags[BIT_FBIT])
    else $error("framing bit error not latched");

  a_fe_in_frame: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (frm_state == ST_INFRAME && !thr_hit) |=>
      (frm_state == ST_INFRAME))
    else $error("frame lost below threshold");

  a_irq_masked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ((flags & enable & STICKY_MASK) == 8'h00) [*2] |-> !irq_o)
    else $error("interrupt without enabled flag");

  a_enable_reset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (enable == ENABLE_RST && !irq_o))
    else $error("enables not cleared by reset");

  a_wclr_set_wins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (clr[BIT_CRC6] && rx_evt_i.crc6_err) |=> flags[BIT_CRC6])
    else $error("clear beat a coincident event");

  a_reset_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (flags == STATUS_RST))
    else $error("status not zero after reset");
endmodule
`default_nettype wire

// ===== sim/t1fis_top_tb.sv
`default_nettype none
module t1fis_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import t1fis_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  t1fis_rx_s rx_evt_i = '0;
  t1fis_sig_s sig_i = '0;
  logic yel_ingress_i = 1'b0;
  logic yel_egress_i = 1'b0;
  logic frame_loss_o;
  logic irq_o;
  int bad_count = 0;
  int tests_run = 0;
  // bench model of the register file and framer state
  logic [7:0] m_st = 8'h00;
  logic [7:0] m_en = 8'h00;
  logic [7:0] m_ctrl = 8'h00;
  logic m_loss = 1'b0;
  int win_bits = 0;
  int win_errs = 0;
  int m_thr = int'(LOSS_THR_RST);
  int m_win = int'(LOSS_WIN_RST);
  int sig_last[24];
  logic [31:0] seed = 32'h0000_e7ca;
  logic [31:0] rd;

  always #50 clk_i = ~clk_i;

  t1fis_top #(.NCH(24)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_evt_i(rx_evt_i), .sig_i(sig_i), .yel_ingress_i(yel_ingress_i),
    .yel_egress_i(yel_egress_i), .frame_loss_o(frame_loss_o), .irq_o(irq_o)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic final_report();
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp, input string nm);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t pin %s is %b expected %b", $time, nm, got, exp);
    end
  endtask

  // one classic cycle, released only after ack is sampled
  task automatic wb_xfer(input logic we, input logic [3:0] adr,
                         input logic [31:0] dat, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      $display("FAIL %0t no acknowledge", $time);
      final_report();
    end
  endtask

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000, rd);
    chk_reg(rd, exp);
  endtask

  task automatic rd_stat();
    logic live;
    live = m_ctrl[CTRL_YEL_SW] ? yel_egress_i : yel_ingress_i;
    rd_chk(OFS_STATUS, {24'h00_0000, m_st[7], live, m_st[5:0]});
    m_st = 8'h00;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] dat);
    logic [7:0] c;
    wb_xfer(1'b1, adr, dat, rd);
    c = dat[7:0] & CTRL_MASK;
    if (adr == OFS_STATUS) m_st = m_st & ~(dat[7:0] & WCLR_MASK);
    if (adr == OFS_ENABLE) m_en = dat[7:0] & STICKY_MASK;
    if (adr == OFS_LOSS) begin
      m_thr = int'(dat[LOSS_THR_LSB +: LOSS_W]);
      m_win = int'(dat[LOSS_WIN_LSB +: LOSS_W]);
    end
    if (adr == OFS_CTRL) begin
      if (c[CTRL_YEL_SW] != m_ctrl[CTRL_YEL_SW] &&
          yel_egress_i != yel_ingress_i) m_st[7] = 1'b1;
      m_ctrl = c;
    end
  endtask

  task automatic pulse(input t1fis_rx_s e);
    @(posedge clk_i);
    rx_evt_i <= e;
    @(posedge clk_i);
    rx_evt_i <= '0;
    m_st[4] |= e.align_shift;
    m_st[2] |= e.mimic;
    m_st[1] |= e.crc6_err;
    m_st[0] |= e.fbit_err;
    // framing bits are only counted while in frame
    if ((e.fbit_ok || e.fbit_err) && !m_loss) begin
      win_bits++;
      win_errs += int'(e.fbit_err);
      if (m_thr != 0 && win_errs >= m_thr) begin
        m_loss = 1'b1;
        m_st[3] = 1'b1;
        win_bits = 0;
        win_errs = 0;
      end else if (win_bits >= m_win) begin
        win_bits = 0;
        win_errs = 0;
      end
    end
    if (e.reframe && m_loss) begin
      m_loss = 1'b0;
      m_st[3] = 1'b1;
    end
  endtask

  task automatic sig(input logic [4:0] ch, input logic [3:0] v);
    @(posedge clk_i);
    sig_i <= {1'b1, ch, v};
    @(posedge clk_i);
    sig_i <= '0;
    if (ch < 24) begin
      if (m_ctrl[CTRL_RBS_EN] && sig_last[ch] >= 0 && sig_last[ch] != int'(v))
        m_st[5] = 1'b1;
      sig_last[ch] = int'(v);
    end
  endtask

  task automatic pins();
    repeat (3) @(posedge clk_i);
    chk_pin(irq_o, |(m_st & m_en), "irq");
    chk_pin(frame_loss_o, m_loss, "frame_loss");
  endtask

  initial begin
    foreach (sig_last[i]) sig_last[i] = -1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_stat();
    rd_chk(OFS_ENABLE, 32'h0000_0000);
    rd_chk(OFS_CTRL, 32'h0000_0000);
    rd_chk(OFS_LOSS, 32'h0000_0402);
    wr(4'h2, 32'hFFFF_FFFF);
    rd_chk(4'h2, 32'h0000_0000);
    // each event alone, then a second read must come back clear
    for (int i = 0; i < 4; i++) begin
      pulse(t1fis_rx_s'(6'h20 >> i));
      rd_stat();
      rd_stat();
    end
    pins();
    repeat (3) pulse(6'h02);
    wr(OFS_ENABLE, 32'h0000_0002);
    rd_chk(OFS_ENABLE, 32'h0000_0002);
    pulse(6'h08);
    pins();
    pulse(6'h10);
    rd_stat();
    pins();
    pulse(6'h10);
    pins();
    wr(OFS_STATUS, 32'h0000_0004);
    rd_stat();
    // yellow alarm on the line side, then switch to the egress input
    @(posedge clk_i);
    yel_ingress_i <= 1'b1;
    m_st[7] = 1'b1;
    repeat (3) @(posedge clk_i);
    rd_stat();
    rd_stat();
    wr(OFS_CTRL, 32'h0000_0004);
    pulse(6'h10);
    wr(OFS_STATUS, 32'h0000_00FF);
    rd_stat();
    // signaling changes, first with robbed-bit signaling off
    sig(5'd3, 4'h5);
    sig(5'd3, 4'hA);
    rd_stat();
    wr(OFS_CTRL, 32'h0000_000C);
    sig(5'd3, 4'hA);
    sig(5'd24, 4'h1);
    sig(5'd24, 4'h2);
    rd_stat();
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      sig(5'(i * 10), seed[3:0]);
      rd_stat();
      sig(5'(i * 10), seed[3:0] ^ (seed[7:4] | 4'h1));
      rd_stat();
    end
    // frame loss at two errors in one window, then reframe
    seed = lfsr(seed);
    wr(OFS_ENABLE, seed | 32'h0000_0008);
    pulse(6'h04);
    pulse(6'h04);
    pins();
    rd_stat();
    pulse(6'h01);
    pins();
    rd_stat();
    // threshold of one in a window of three
    wr(OFS_LOSS, 32'h0000_0301);
    rd_chk(OFS_LOSS, 32'h0000_0301);
    pulse(6'h02);
    pulse(6'h04);
    pins();
    rd_stat();
    pulse(6'h01);
    pins();
    rd_stat();
    // crc-6 event on the same edge as its write clear
    fork
      wr(OFS_STATUS, 32'h0000_0002);
      begin
        @(posedge clk_i);
        rx_evt_i <= 6'h08;
        @(posedge clk_i);
        rx_evt_i <= '0;
      end
    join
    m_st[1] = 1'b1;
    rd_stat();
    rd_stat();
    final_report();
  end
endmodule
`default_nettype wire
